// File: hw/fpba_arbiter.sv
// Purpose: Four-port pipelined bus arbiter with control register.
// Assumes: Masters hold req until done; addrFree marks a free address phase.
// Notes:   Plain register port, read data one cycle after the read strobe.
`timescale 1ns/1ps
`include "fpba_map.svh"

module fpba_arbiter #(
   parameter int CNT_W = 16
) (
   input  wire logic                core_clk,
   input  wire logic                reset,
   input  wire logic [3:0]          regAddr,
   input  wire logic [31:0]         regWdata,
   input  wire logic                regWr,
   input  wire logic                regRd,
   output logic      [31:0]         regRdata,
   input  wire logic [3:0]          busReq,
   input  wire logic [3:0]          xferDone,
   input  wire logic                addrFree,
   input  wire logic                dmaBoostReq,
   output logic      [3:0]          busGrant,
   output logic      [1:0]          busOwner,
   output logic                     ownerValid,
   output logic                     dmaCountWidth24
);

   ////////////////////////////////////////////////////////////////////////
   // Register port
   logic [31:0]          ctrl_r;
   logic [31:0]          rdata_r;
   logic [31:0]          rdataNxt;
   fpba_pkg::fpba_ctrl_s cfg;
   logic                 wrCtrl;
   logic                 rdCtrl;
   logic                 rdStat;
   logic [31:0]          statusWord;
   fpba_pkg::fpba_regreq_s regReq;

   // Bundle the plain port so decode reads one carrier
   assign regReq.addr  = regAddr;
   assign regReq.wdata = regWdata;
   assign regReq.wr    = regWr;
   assign regReq.rd    = regRd;

   assign wrCtrl = regReq.wr && (regReq.addr == `FPBA_CTRL_ADDR);
   assign rdCtrl = regReq.rd && (regReq.addr == `FPBA_CTRL_ADDR);
   assign rdStat = regReq.rd && (regReq.addr == `FPBA_STAT_ADDR);

   assign cfg.boostEn   = ctrl_r[`FPBA_BIT_BOOST];
   assign cfg.width24   = ctrl_r[`FPBA_BIT_WIDTH24];
   assign cfg.priEth    = ctrl_r[`FPBA_POS_PRI_ETH+:2];
   assign cfg.priDma    = ctrl_r[`FPBA_POS_PRI_DMA+:2];
   assign cfg.priCore   = ctrl_r[`FPBA_POS_PRI_CORE+:2];
   assign cfg.priInt    = ctrl_r[`FPBA_POS_PRI_INT+:2];
   assign cfg.fixedMode = ctrl_r[`FPBA_BIT_FIXED];
   assign cfg.starveEn  = ctrl_r[`FPBA_BIT_STARVE];
   assign cfg.parkTop   = ctrl_r[`FPBA_BIT_PARKTOP];
   assign cfg.limitExp  = ctrl_r[`FPBA_POS_LIMIT+:4];

   assign dmaCountWidth24 = cfg.width24;

   ////////////////////////////////////////////////////////////////////////
   // Priority table
   logic [1:0] priRaw [4];
   logic [1:0] pri    [4];
   logic       priUnique;

   assign priRaw[0] = cfg.priCore;
   assign priRaw[1] = cfg.priInt;
   assign priRaw[2] = cfg.priDma;
   assign priRaw[3] = cfg.priEth;

   assign priUnique = (priRaw[0] != priRaw[1]) && (priRaw[0] != priRaw[2])
                   && (priRaw[0] != priRaw[3]) && (priRaw[1] != priRaw[2])
                   && (priRaw[1] != priRaw[3]) && (priRaw[2] != priRaw[3]);

   assign pri[0] = priUnique ? priRaw[0] : `FPBA_DEF_PRI_CORE;
   assign pri[1] = priUnique ? priRaw[1] : `FPBA_DEF_PRI_INT;
   assign pri[2] = priUnique ? priRaw[2] : `FPBA_DEF_PRI_DMA;
   assign pri[3] = priUnique ? priRaw[3] : `FPBA_DEF_PRI_ETH;

   ////////////////////////////////////////////////////////////////////////
   // Arbitration state
   fpba_pkg::fpba_state_e state_r;
   fpba_pkg::fpba_state_e stateNxt;
   logic [1:0]            ptr_r;
   logic [1:0]            ptrNxt;
   logic [1:0]            owner_r;
   logic [1:0]            ownerNxt;
   logic [1:0]            last_r;
   logic                  valid_r;
   logic                  validNxt;
   logic [3:0]            lockOut;
   logic                  useRr;
   logic [3:0]            candReq;
   logic [3:0]            denied;
   logic                  immGrant;
   logic                  ownerBusy;
   logic [1:0]            winner;
   logic                  anyCand;
   logic [1:0]            topPort;
   logic [1:0]            parkPtr;
   logic [3:0]            ownerMask;
   logic                  starveOn;

   ////////////////////////////////////////////////////////////////////////
   // Helper functions

   // One-hot mask of a port index
   function automatic logic [3:0] port_bit(input logic [1:0] idx);
      return 4'h1 << idx;
   endfunction

   // Best requester by score: effective priority plus DMA boost
   function automatic logic [1:0] pick_best(
      input logic [3:0] req,
      input logic [1:0] base,
      input logic       rr,
      input logic       boost,
      input logic [1:0] p0,
      input logic [1:0] p1,
      input logic [1:0] p2,
      input logic [1:0] p3
   );
      logic [1:0] pv [4];
      logic [2:0] score;
      logic [2:0] best;
      logic [1:0] sel;
      logic [1:0] eff;
      logic       found;
      pv[0] = p0;
      pv[1] = p1;
      pv[2] = p2;
      pv[3] = p3;
      best  = 3'h0;
      sel   = 2'h0;
      found = 1'b0;
      for (int i = 0; i < 4; i++) begin
         eff   = rr ? 2'(pv[i] + base) : pv[i];
         score = {1'b0, eff};
         if (boost && (2'(i) == `FPBA_PORT_DMA)) score = 3'h4;
         // Strictly greater, so ties keep the lower port
         if (req[i] && (!found || (score > best))) begin
            best  = score;
            sel   = 2'(i);
            found = 1'b1;
         end
      end
      return sel;
   endfunction

   assign useRr = !cfg.fixedMode || (|lockOut);

   assign ownerBusy = valid_r && busReq[owner_r] && !xferDone[owner_r];

   assign immGrant = !ownerBusy && addrFree && busReq[ptr_r];

   always_comb begin
      candReq = busReq;
      if (immGrant) candReq[ptr_r] = 1'b0;
      if (ownerBusy) candReq[owner_r] = 1'b0;
   end
   assign anyCand = |candReq;

   assign winner = pick_best(candReq,
                             immGrant ? pri[ptr_r] : pri[owner_r],
                             useRr, cfg.boostEn && dmaBoostReq,
                             pri[0], pri[1], pri[2], pri[3]);
   assign topPort = pick_best(4'hF, 2'h0, 1'b0, 1'b0,
                              pri[0], pri[1], pri[2], pri[3]);

   assign parkPtr = cfg.parkTop ? topPort : last_r;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      stateNxt = state_r;
      ptrNxt   = ptr_r;
      ownerNxt = owner_r;
      validNxt = ownerBusy;
      if (immGrant) begin
         ownerNxt = ptr_r;
         validNxt = 1'b1;
      end
      case (state_r)
         fpba_pkg::FPBA_IDLE,
         fpba_pkg::FPBA_OWNED,
         fpba_pkg::FPBA_PARK: begin
            if (anyCand) begin
               ptrNxt   = winner;
               stateNxt = fpba_pkg::FPBA_OWNED;
            end else if (!immGrant && !ownerBusy && !busReq[ptr_r]) begin
               ptrNxt   = parkPtr;
               stateNxt = fpba_pkg::FPBA_PARK;
            end
         end
         default: stateNxt = fpba_pkg::FPBA_IDLE;
      endcase
   end

   assign starveOn  = cfg.fixedMode && cfg.starveEn;
   // Busy owner is served, not starving
   assign ownerMask = ownerBusy ? port_bit(owner_r) : 4'h0;
   assign denied    = starveOn ? (busReq & ~busGrant & ~ownerMask) : 4'h0;

   fpba_starve_cnt #(
      .CNT_W (CNT_W)
   ) uStarve (
      .core_clk (core_clk),
      .reset    (reset),
      .countEn  (starveOn),
      .denied   (denied),
      .limitExp (cfg.limitExp),
      .lockOut  (lockOut)
   );

   assign busGrant   = immGrant ? port_bit(ptr_r) : 4'h0;
   assign busOwner   = owner_r;
   assign ownerValid = valid_r;

   ////////////////////////////////////////////////////////////////////////
   // Registers
   // synchronous update and reset
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_r <= fpba_pkg::FPBA_IDLE;
         ptr_r   <= `FPBA_PORT_ETH;
         owner_r <= `FPBA_PORT_CORE;
         last_r  <= `FPBA_PORT_ETH;
         valid_r <= 1'b0;
      end else begin
         state_r <= stateNxt;
         ptr_r   <= ptrNxt;
         owner_r <= ownerNxt;
         valid_r <= validNxt;
         if (immGrant) last_r <= ptr_r;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ctrl_r <= `FPBA_CTRL_RESET;
      end else if (wrCtrl) begin
         ctrl_r <= regReq.wdata & `FPBA_CTRL_WMASK;
      end
   end

   // Status: lock-out flags, owner valid, owner, pointer
   assign statusWord = {20'h00000, lockOut, 1'b0, valid_r, owner_r,
                        2'h0, ptr_r};

   // Unmapped or idle reads return zero
   assign rdataNxt = rdCtrl ? ctrl_r :
                     rdStat ? statusWord : 32'h00000000;

   always_ff @(posedge core_clk) begin
      if (reset) rdata_r <= 32'h00000000;
      else rdata_r <= rdataNxt;
   end
   assign regRdata = rdata_r;

endmodule // fpba_arbiter

// File: hw/fpba_map.svh
// Purpose: Register map, field positions and reset values of the arbiter.
// Assumes: One 32-bit control word at a single address on the plain port.
// Notes:   Used by fpba_pkg users and the arbiter core.
`ifndef FPBA_MAP_SVH
`define FPBA_MAP_SVH

`define FPBA_ADDR_W          4
`define FPBA_CTRL_ADDR       4'h0
`define FPBA_STAT_ADDR       4'h4
`define FPBA_CTRL_WMASK      32'h03FF7F00
`define FPBA_CTRL_RESET      32'h00E10000
`define FPBA_BIT_BOOST       25
`define FPBA_BIT_WIDTH24     24
`define FPBA_POS_PRI_ETH     22
`define FPBA_POS_PRI_DMA     20
`define FPBA_POS_PRI_CORE    18
`define FPBA_POS_PRI_INT     16
`define FPBA_BIT_FIXED       14
`define FPBA_BIT_STARVE      13
`define FPBA_BIT_PARKTOP     12
`define FPBA_POS_LIMIT       8
`define FPBA_DEF_PRI_ETH     2'h3
`define FPBA_DEF_PRI_DMA     2'h2
`define FPBA_DEF_PRI_INT     2'h1
`define FPBA_DEF_PRI_CORE    2'h0
`define FPBA_PORT_CORE       2'h0
`define FPBA_PORT_INT        2'h1
`define FPBA_PORT_DMA        2'h2
`define FPBA_PORT_ETH        2'h3

`endif

// File: hw/fpba_pkg.sv
// Purpose: Types shared by the four-port bus arbiter.
// Assumes: Four masters, two-bit port index.
// Notes:   Constants live in fpba_map.svh.
package fpba_pkg;

   typedef logic [1:0] fpba_port_t;
   typedef logic [3:0] fpba_req_t;

   // Decoded control word
   typedef struct packed {
      logic       boostEn;
      logic       width24;
      logic [1:0] priEth;
      logic [1:0] priDma;
      logic [1:0] priCore;
      logic [1:0] priInt;
      logic       fixedMode;
      logic       starveEn;
      logic       parkTop;
      logic [3:0] limitExp;
   } fpba_ctrl_s;

   // Register port request
   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } fpba_regreq_s;

   typedef enum logic [1:0] {
      FPBA_IDLE  = 2'b00,
      FPBA_OWNED = 2'b01,
      FPBA_PARK  = 2'b11
   } fpba_state_e;

endpackage

// File: hw/fpba_starve_cnt.sv
// Purpose: Per-master starvation counters with lock-out flags.
// Assumes: Counters run only in fixed mode with counting enabled.
// Notes:   A flag clears when its master gets the bus or stops asking.
`timescale 1ns/1ps
`include "fpba_map.svh"

module fpba_starve_cnt #(
   parameter int CNT_W = 16
) (
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic             countEn,
   input  wire logic [3:0]       denied,
   input  wire logic [3:0]       limitExp,
   output logic      [3:0]       lockOut
);

   logic [CNT_W-1:0] cnt_r [4];
   logic [3:0]       lockOut_r;
   logic [CNT_W:0]   limitVal;

   assign limitVal = (CNT_W+1)'(1) << limitExp;
   assign lockOut  = lockOut_r;

   always_ff @(posedge core_clk) begin
      for (int i = 0; i < 4; i++) begin
         if (reset || !countEn || !denied[i]) begin
            cnt_r[i]     <= '0;
            lockOut_r[i] <= 1'b0;
         end else begin
            if (!(&cnt_r[i])) cnt_r[i] <= cnt_r[i] + 1'b1;
            if ({1'b0, cnt_r[i]} + 1'b1 >= limitVal) begin
               lockOut_r[i] <= 1'b1;
            end
         end
      end
   end

endmodule // fpba_starve_cnt

// File: verif/four_port_bus_arbiter_tb_top.sv
// Purpose: Self-checking bench for the bus arbiter.
// Assumes: Control at 0x0, status at 0x4, pointer in status [1:0].
// Notes:   Rows check pointer choice with the address phase held busy.
`timescale 1ns/1ps

module four_port_bus_arbiter_tb_top;
   typedef struct {logic [31:0] c; logic [3:0] g; logic b; logic [1:0] p;}
      fpba_row_s;
   logic        core_clk, reset, regWr, regRd, addrFree, dmaBoostReq;
   logic [3:0]  regAddr, busReq, xferDone, busGrant, go;
   logic [31:0] regWdata, regRdata, d;
   logic [1:0]  busOwner;
   logic        ownerValid, dmaCountWidth24;
   int          err_total = 0;
   int          n_compared = 0;
   fpba_row_s   rows [13] = '{
      '{32'h00E14000, 4'h3, 1'b0, 2'h1},
      '{32'h00E14000, 4'h5, 1'b0, 2'h2},
      '{32'h009C4000, 4'h3, 1'b0, 2'h0},
      '{32'h009C4000, 4'hC, 1'b0, 2'h3},
      '{32'h00004000, 4'h3, 1'b0, 2'h1},
      '{32'h009C5000, 4'h0, 1'b0, 2'h0},
      '{32'h00E15000, 4'h0, 1'b0, 2'h3},
      '{32'h00E14000, 4'h0, 1'b0, 2'h0},
      '{32'h02E14000, 4'hC, 1'b1, 2'h2},
      '{32'h009C0000, 4'h7, 1'b0, 2'h1},
      '{32'h009C0000, 4'h6, 1'b0, 2'h1},
      '{32'h009C2F00, 4'h6, 1'b0, 2'h1},
      '{32'h009C4000, 4'h6, 1'b0, 2'h2}};

   fpba_arbiter #(.CNT_W(16)) i_fpba_arbiter (.core_clk(core_clk),
      .reset(reset), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .busReq(busReq),
      .xferDone(xferDone), .addrFree(addrFree), .dmaBoostReq(dmaBoostReq),
      .busGrant(busGrant), .busOwner(busOwner), .ownerValid(ownerValid),
      .dmaCountWidth24(dmaCountWidth24));
   fpba_master_model #(.HOLD(3)) i_fpba_master_model (.core_clk(core_clk),
      .reset(reset), .go(go), .busGrant(busGrant), .busReq(busReq),
      .xferDone(xferDone));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic regWrite(input logic [3:0] a, input logic [31:0] v);
      @(posedge core_clk);
      regWr <= 1'b1; regAddr <= a; regWdata <= v;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask
   task automatic regRead(input logic [3:0] a, output logic [31:0] v);
      @(posedge core_clk);
      regRd <= 1'b1; regAddr <= a;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 v = regRdata;
   endtask
   task automatic waitGrant(input logic [3:0] m);
      int n;
      for (n = 0; n < 40 && (busGrant & m) == 4'h0; n++)
         @(posedge core_clk) #1;
      if (n == 40) begin
         err_total++;
         $display("CHECK FAILED %0t no grant", $time);
         finish_test();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      reset = 1'b1; regWr = 1'b0; regRd = 1'b0; regAddr = 4'h0;
      regWdata = 32'h0; addrFree = 1'b0; dmaBoostReq = 1'b0; go = 4'h0;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      go <= 4'h9;
      addrFree <= 1'b1;
      waitGrant(4'hF);
      chk(busGrant, 4'h8);
      @(posedge core_clk) #1;
      go <= 4'h1;
      chk({ownerValid, busOwner}, 3'h7);
      waitGrant(4'h1);
      chk(busGrant, 4'h1);
      @(posedge core_clk);
      go <= 4'h0;
      addrFree <= 1'b0;
      #1 chk({ownerValid, busOwner}, 3'h4);
      regRead(4'h0, d);
      chk(d, 32'h00E10000);
      regWrite(4'h0, 32'h03FD7F00);
      regRead(4'h0, d);
      chk(d, 32'h03FD7F00);
      chk(dmaCountWidth24, 1'b1);
      regWrite(4'h8, 32'hFFFFFFFF);
      regRead(4'h8, d);
      chk(d, 32'h0);
      foreach (rows[i]) begin
         regWrite(4'h0, rows[i].c);
         dmaBoostReq <= rows[i].b;
         go <= rows[i].g;
         repeat (4) @(posedge core_clk);
         regRead(4'h4, d);
         chk(d[1:0], rows[i].p);
         chk(dmaCountWidth24, 1'b0);
      end
      // Fixed mode, counting on, limit of four denied cycles
      regWrite(4'h0, 32'h009C6200);
      regRead(4'h4, d);
      chk(d[11:0], 12'h002);
      repeat (4) @(posedge core_clk);
      regRead(4'h4, d);
      chk(d[11:0], 12'h601);
      go <= 4'h0;
      repeat (3) @(posedge core_clk);
      regRead(4'h4, d);
      chk(d[11:0], 12'h000);
      finish_test();
   end
endmodule // four_port_bus_arbiter_tb_top

// File: verif/fpba_arbiter_sva.sv
// Purpose: Port assertions for the four-port bus arbiter.
// Assumes: Sees only the arbiter top ports.
// Notes:   Grant, ownership and register-port relations.
`timescale 1ns/1ps

module fpba_arbiter_chk #(
   parameter int CNT_W = 16
) (
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic [3:0]  regAddr,
   input wire logic [31:0] regWdata,
   input wire logic        regWr,
   input wire logic        regRd,
   input wire logic [31:0] regRdata,
   input wire logic [3:0]  busReq,
   input wire logic [3:0]  xferDone,
   input wire logic        addrFree,
   input wire logic [3:0]  busGrant,
   input wire logic [1:0]  busOwner,
   input wire logic        ownerValid,
   input wire logic        dmaCountWidth24
);
   wire logic [1:0] gIdx;
   wire logic       busy;
   assign gIdx = {busGrant[3] | busGrant[2], busGrant[3] | busGrant[1]};
   assign busy = ownerValid && busReq[busOwner] && !xferDone[busOwner];
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   grant_needs_free_a: assert property (
      busGrant != 4'h0 |-> addrFree) else $error("grant without free phase");
   grant_needs_req_a: assert property (
      (busGrant & ~busReq) == 4'h0) else $error("grant without request");
   grant_onehot_a: assert property (
      $onehot0(busGrant)) else $error("more than one grant");
   grant_owner_a: assert property (
      busGrant != 4'h0 |=> ownerValid && busOwner == $past(gIdx))
      else $error("granted master not owner");
   busy_no_grant_a: assert property (
      busy |-> busGrant == 4'h0) else $error("grant while owner busy");
   busy_keeps_a: assert property (
      busy |=> ownerValid && $stable(busOwner)) else $error("owner lost");
   width_export_a: assert property (
      regWr && regAddr == 4'h0 |=> dmaCountWidth24 == $past(regWdata[24]))
      else $error("count width not exported");
   reserved_zero_a: assert property (
      $past(regRd) && $past(regAddr) == 4'h0 |->
      (regRdata & 32'hFC0080FF) == 32'h0) else $error("reserved bit set");
endmodule // fpba_arbiter_chk

bind fpba_arbiter fpba_arbiter_chk #(.CNT_W(CNT_W)) i_fpba_arbiter_chk (
   .core_clk(core_clk), .reset(reset), .regAddr(regAddr),
   .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
   .busReq(busReq), .xferDone(xferDone), .addrFree(addrFree),
   .busGrant(busGrant), .busOwner(busOwner), .ownerValid(ownerValid),
   .dmaCountWidth24(dmaCountWidth24));

// File: verif/fpba_master_model.sv
// Purpose: Four bus masters facing the arbiter.
// Assumes: go[i] asks master i to request; HOLD cycles per transfer.
// Notes:   An unserved request may be withdrawn when go falls.
`timescale 1ns/1ps

module fpba_master_model #(
   parameter int HOLD = 3
) (
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic [3:0] go,
   input  wire logic [3:0] busGrant,
   output logic      [3:0] busReq,
   output logic      [3:0] xferDone
);
   logic [3:0] owned;
   int         cnt [4];
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < 4; i++) begin
         xferDone[i] <= 1'b0;
         if (reset) begin
            busReq[i] <= 1'b0;
            owned[i]  <= 1'b0;
         end else if (busGrant[i]) begin
            owned[i] <= 1'b1;
            cnt[i]   <= HOLD;
         end else if (owned[i] && xferDone[i]) begin
            busReq[i] <= 1'b0;
            owned[i]  <= 1'b0;
         end else if (owned[i]) begin
            cnt[i] <= cnt[i] - 1;
            xferDone[i] <= (cnt[i] == 1);
         end else begin
            busReq[i] <= go[i];
         end
      end
   end
endmodule // fpba_master_model
